// >>> verilog/dbu_uart.sv
// Purpose: Four-mode debug serial port with rate selection and buffers.
// Assumes: Timer overflow pulses are one core clock wide, same clock.
// Notes: Read data appears on the clock after the read strobe.
`timescale 1ns/100ps

// Notes on behaviour
// - Hardware flag sets win over firmware control writes.
// - Two mode bits pick one of four modes.
// - Data address: write transmits, read returns receive.
// - Firmware cannot read transmit or write receive.
// - Mode 0 shifts one bit per six clocks.
// - Mode 2 bit rate is clock/64 or clock/32.
// - Modes 1 and 3 time from timer overflows.
// - Transmit select bit: timer1 clear, timer2 set.
// - Receive select bit chooses its own timer.
// - Timer1 trigger is overflow/32, or /16 doubled.
// - Timer2 trigger is overflow/16 regardless of doubling.
// - Timer1 auto-reload gives the stated bit rate.
// - Any timer1 configuration may drive the rate.
// - Timer2 baud mode gives clock/16/(65536-reload).
// - All rates come from the core clock.
// - Timer1 fastest setting: 96 clocks per bit.
// - Timer2 fastest setting: 16 clocks per bit.
// - Transmit done after eighth or ninth bit.
// - Receive done one clock after final sample.
// - Multiprocessor filter blocks flag and buffer loads.
// - Reception starts only while receive enable is set.
module dbu_uart import dbu_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_rate_double,
  input wire logic i_tx_timer_select,
  input wire logic i_rx_timer_select,
  input wire logic i_timer1_overflow_pulse,
  input wire logic i_timer2_overflow_pulse,
  input wire logic i_rxd,
  output logic o_rxd,
  output logic o_rxd_oe,
  output logic o_txd,
  output logic o_tx_done_flag,
  output logic o_rx_done_flag,
  output logic o_txbuf_ready
);

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic [7:0] scon;
    logic [7:0] rx_data;
    logic [7:0] rdata;
    logic [1:0] m2_cnt;
    logic t1_half;
    logic tx_busy;
    logic [3:0] tx_idx;
    logic [3:0] tx_tcnt;
    logic [8:0] tx_shift;
    dbu_rx_state_t rx_st;
    logic [3:0] rx_idx;
    logic [3:0] rx_tcnt;
    logic [7:0] rx_shift;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } dbu_uart_state_t;

  localparam dbu_uart_state_t STATE_RESET = '{
    rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1,
    scon: DBU_SCON_RESET, rx_data: DBU_SDATA_RESET,
    rdata: 8'h00, m2_cnt: 2'h0, t1_half: 1'b0, tx_busy: 1'b0,
    tx_idx: 4'h0, tx_tcnt: 4'h0, tx_shift: 9'h000,
    rx_st: DBU_RX_IDLE, rx_idx: 4'h0, rx_tcnt: 4'h0,
    rx_shift: 8'h00, txd: 1'b1, rxd_out: 1'b1, rxd_oe: 1'b0};

  localparam logic [1:0] M2_LAST_SLOW = 2'(DBU_M2_PRE_SLOW - 1);
  localparam logic [1:0] M2_LAST_FAST = 2'(DBU_M2_PRE_FAST - 1);
  localparam logic [3:0] RX_MID = 4'(DBU_RX_MID_TICK);
  localparam logic [3:0] LAST_DATA = 4'(DBU_LAST_DATA_IDX);
  localparam logic [3:0] FINAL_IDX = 4'(DBU_FINAL_IDX);
  localparam logic [3:0] M0_HALF = 4'(DBU_MODE0_BIT_CLKS / 2);

  dbu_uart_state_t state_reg;
  dbu_uart_state_t state_next;
  dbu_mode_t mode;
  logic m2_tick;
  logic t1_tick;
  logic tx_tick;
  logic rx_tick;
  logic tx_bit_end;
  logic tx_done_evt;
  logic rx_sample;
  logic rx_final;
  logic rx_accept;

  dbu_stream_if #(.W(DBU_STREAM_W)) tx_in ();
  dbu_stream_if #(.W(DBU_STREAM_W)) tx_out ();

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Mode 0 ticks every clock; mode 2 uses the core prescaler; the
  // variable modes never see the core clock directly.
  function automatic logic sel_tick(input dbu_mode_t m, input logic sel,
                                    input logic m2, input logic t1,
                                    input logic t2);
    case (m)
      DBU_MODE_SHIFT: sel_tick = 1'b1;
      DBU_MODE_9FIX: sel_tick = m2;
      default: sel_tick = sel ? t2 : t1;
    endcase
  endfunction

  function automatic logic [3:0] bit_last(input dbu_mode_t m);
    bit_last = (m == DBU_MODE_SHIFT) ? 4'(DBU_MODE0_BIT_CLKS - 1)
                                     : 4'(DBU_TICKS_PER_BIT - 1);
  endfunction

  function automatic logic [3:0] data_bits(input dbu_mode_t m);
    data_bits = m[1] ? 4'h9 : 4'h8;
  endfunction

  // ****************************************************************
  // Rate generation
  // ****************************************************************
  assign mode = dbu_mode_t'(state_reg.scon[DBU_MODE_HI_POS:
                                            DBU_MODE_LO_POS]);
  assign m2_tick = state_reg.m2_cnt >=
                   (i_rate_double ? M2_LAST_FAST : M2_LAST_SLOW);
  // Timer1 pulses are halved unless doubling; timer2 passes straight.
  assign t1_tick = i_timer1_overflow_pulse &&
                   (i_rate_double || state_reg.t1_half);
  assign tx_tick = sel_tick(mode, i_tx_timer_select, m2_tick, t1_tick,
                            i_timer2_overflow_pulse);
  assign rx_tick = sel_tick(mode, i_rx_timer_select, m2_tick, t1_tick,
                            i_timer2_overflow_pulse);

  // ****************************************************************
  // Transmit and receive events
  // ****************************************************************
  assign tx_bit_end = state_reg.tx_busy && tx_tick &&
                      (state_reg.tx_tcnt == bit_last(mode));
  assign tx_done_evt = tx_bit_end &&
                       (state_reg.tx_idx == data_bits(mode));
  assign rx_sample = (state_reg.rx_st == DBU_RX_SHIFT) ?
                     (state_reg.rx_tcnt == bit_last(mode)) :
                     ((state_reg.rx_st == DBU_RX_FRAME) && rx_tick &&
                      (state_reg.rx_tcnt == RX_MID));
  assign rx_final = rx_sample &&
                    (state_reg.rx_idx == ((state_reg.rx_st ==
                     DBU_RX_SHIFT) ? LAST_DATA : FINAL_IDX));
  assign rx_accept = rx_final && (mode == DBU_MODE_SHIFT ||
                     !state_reg.scon[DBU_MULTIPROC_POS] ||
                     state_reg.rx_sync);

  assign tx_in.valid = i_sfr_wr && (i_sfr_addr == DBU_SDATA_ADDR);
  assign tx_in.data = {state_reg.scon[DBU_TX_NINTH_POS], i_sfr_wdata};
  // Transmit waits while a mode 0 receive owns the shift pins.
  assign tx_out.ready = !state_reg.tx_busy &&
                        (state_reg.rx_st != DBU_RX_SHIFT);

  dbu_buf2 #(.W(DBU_STREAM_W), .DEPTH(DBU_BUF_DEPTH)) u_txbuf (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in(tx_in.snk),
    .o_out(tx_out.src)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rx_meta = i_rxd;
    state_next.rx_sync = state_reg.rx_meta;
    state_next.rx_prev = state_reg.rx_sync;
    state_next.m2_cnt = m2_tick ? 2'h0 : 2'(state_reg.m2_cnt + 2'h1);
    if (i_timer1_overflow_pulse) begin
      state_next.t1_half = !state_reg.t1_half;
    end

    // Only the control register takes firmware data; the receive
    // buffer is loaded by the receiver alone.
    if (i_sfr_wr && i_sfr_addr == DBU_SCON_ADDR) begin
      state_next.scon = i_sfr_wdata;
    end
    if (i_sfr_rd) begin
      if (i_sfr_addr == DBU_SCON_ADDR) begin
        state_next.rdata = state_reg.scon;
      end else if (i_sfr_addr == DBU_SDATA_ADDR) begin
        state_next.rdata = state_reg.rx_data;
      end else begin
        state_next.rdata = 8'h00;
      end
    end

    if (!state_reg.tx_busy) begin
      if (tx_out.valid && tx_out.ready) begin
        state_next.tx_busy = 1'b1;
        state_next.tx_shift = tx_out.data;
        state_next.tx_tcnt = 4'h0;
        state_next.tx_idx = (mode == DBU_MODE_SHIFT) ? 4'h1 : 4'h0;
      end
    end else if (tx_tick) begin
      if (tx_bit_end) begin
        state_next.tx_tcnt = 4'h0;
        if (state_reg.tx_idx != 4'h0 &&
            state_reg.tx_idx <= data_bits(mode)) begin
          state_next.tx_shift = {1'b1, state_reg.tx_shift[8:1]};
        end
        if (state_reg.tx_idx == data_bits(mode) +
            ((mode == DBU_MODE_SHIFT) ? 4'h0 : 4'h1)) begin
          state_next.tx_busy = 1'b0;
        end else begin
          state_next.tx_idx = 4'(state_reg.tx_idx + 4'h1);
        end
      end else begin
        state_next.tx_tcnt = 4'(state_reg.tx_tcnt + 4'h1);
      end
    end

    case (state_reg.rx_st)
      DBU_RX_IDLE: begin
        state_next.rx_tcnt = 4'h0;
        if (state_reg.scon[DBU_RX_EN_POS]) begin
          if (mode == DBU_MODE_SHIFT) begin
            // A queued word wins, so both never start on one edge.
            if (!state_reg.scon[DBU_RX_DONE_POS] &&
                !state_reg.tx_busy && !tx_out.valid) begin
              state_next.rx_st = DBU_RX_SHIFT;
              state_next.rx_idx = 4'h1;
            end
          end else if (state_reg.rx_prev && !state_reg.rx_sync) begin
            state_next.rx_st = DBU_RX_FRAME;
            state_next.rx_idx = 4'h0;
          end
        end
      end
      DBU_RX_FRAME: begin
        if (rx_tick) begin
          state_next.rx_tcnt = 4'(state_reg.rx_tcnt + 4'h1);
        end
        if (rx_sample) begin
          state_next.rx_idx = 4'(state_reg.rx_idx + 4'h1);
          if (state_reg.rx_idx == 4'h0 && state_reg.rx_sync) begin
            state_next.rx_st = DBU_RX_IDLE; // False start, line high.
          end else if (rx_final) begin
            state_next.rx_st = DBU_RX_IDLE;
          end else if (state_reg.rx_idx != 4'h0) begin
            state_next.rx_shift = {state_reg.rx_sync,
                                   state_reg.rx_shift[7:1]};
          end
        end
      end
      DBU_RX_SHIFT: begin
        state_next.rx_tcnt = rx_sample ? 4'h0 :
                             4'(state_reg.rx_tcnt + 4'h1);
        if (rx_sample) begin
          state_next.rx_idx = 4'(state_reg.rx_idx + 4'h1);
          state_next.rx_shift = {state_reg.rx_sync,
                                 state_reg.rx_shift[7:1]};
          if (rx_final) begin
            state_next.rx_st = DBU_RX_IDLE;
          end
        end
      end
      default: state_next.rx_st = DBU_RX_IDLE;
    endcase

    // Flag sets come after the firmware write so that a set in the
    // same cycle as a read-modify-write is never lost.
    if (tx_done_evt) begin
      state_next.scon[DBU_TX_DONE_POS] = 1'b1;
    end
    if (rx_accept) begin
      state_next.scon[DBU_RX_DONE_POS] = 1'b1;
      if (mode == DBU_MODE_SHIFT) begin
        state_next.rx_data = {state_reg.rx_sync, state_reg.rx_shift[7:1]};
      end else begin
        state_next.rx_data = state_reg.rx_shift;
        state_next.scon[DBU_RX_NINTH_POS] = state_reg.rx_sync;
      end
    end

    state_next.rxd_oe = state_next.tx_busy && (mode == DBU_MODE_SHIFT);
    state_next.rxd_out = !state_next.tx_busy ? 1'b1 :
                         (state_next.tx_idx == 4'h0) ? 1'b0 :
                         (state_next.tx_idx <= data_bits(mode)) ?
                         state_next.tx_shift[0] : 1'b1;
    if (mode != DBU_MODE_SHIFT) begin
      state_next.txd = state_next.rxd_out;
    end else if (state_next.tx_busy) begin
      state_next.txd = state_next.tx_tcnt >= M0_HALF;
    end else if (state_next.rx_st == DBU_RX_SHIFT) begin
      state_next.txd = state_next.rx_tcnt >= M0_HALF;
    end else begin
      state_next.txd = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sfr_rdata = state_reg.rdata;
  assign o_rxd = state_reg.rxd_out;
  assign o_rxd_oe = state_reg.rxd_oe;
  assign o_txd = state_reg.txd;
  assign o_tx_done_flag = state_reg.scon[DBU_TX_DONE_POS];
  assign o_rx_done_flag = state_reg.scon[DBU_RX_DONE_POS];
  assign o_txbuf_ready = tx_in.ready;

  // ****************************************************************
  // Checks
  // ****************************************************************
  mode0_bit_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    tx_bit_end && mode == DBU_MODE_SHIFT ##1 mode == DBU_MODE_SHIFT
    |-> !tx_bit_end[*5])
    else $error("Mode 0 bit shorter than six clocks.");

  mode2_rate_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    m2_tick && !i_rate_double |=> (!m2_tick || i_rate_double)[*3])
    else $error("Mode 2 tick faster than one per four clocks.");

  tx_t2_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    mode[0] && i_tx_timer_select |-> tx_tick == i_timer2_overflow_pulse)
    else $error("Transmit tick not following timer2.");

  rx_t1_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    mode[0] && !i_rx_timer_select && i_rate_double
    |-> rx_tick == i_timer1_overflow_pulse)
    else $error("Receive tick not following timer1 when doubled.");

  tx_done_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    $rose(o_tx_done_flag) && !$past(i_sfr_wr)
    |-> $past(state_reg.tx_idx) == data_bits($past(mode)))
    else $error("Transmit done set at the wrong bit.");

  set_wins_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    tx_done_evt && i_sfr_wr && i_sfr_addr == DBU_SCON_ADDR
    |=> o_tx_done_flag)
    else $error("Firmware write overwrote a hardware flag set.");

  rx_done_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    $rose(o_rx_done_flag) && !$past(i_sfr_wr) |-> $past(rx_final))
    else $error("Receive done not one clock after final sample.");

  filter_hold_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    rx_final && mode != DBU_MODE_SHIFT && !state_reg.rx_sync &&
    state_reg.scon[DBU_MULTIPROC_POS] |=> $stable(state_reg.rx_data))
    else $error("Filtered frame loaded the receive buffer.");

  rx_enable_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    state_reg.rx_st == DBU_RX_IDLE && !state_reg.scon[DBU_RX_EN_POS]
    |=> state_reg.rx_st == DBU_RX_IDLE)
    else $error("Reception started while disabled.");

  tx_write_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    tx_in.valid && !rx_accept |=> $stable(state_reg.rx_data))
    else $error("Data write reached the receive buffer.");

endmodule

// >>> shared/dbu_pkg.sv
// Purpose: Shared constants and types of the debug serial port.
// Assumes: One core clock; register port addressed by byte.
// Notes: Divider figures are core clocks per bit or per tick.
package dbu_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] DBU_SCON_ADDR = 8'h98;
  localparam logic [7:0] DBU_SDATA_ADDR = 8'h99;
  localparam logic [7:0] DBU_SCON_RESET = 8'h00;
  localparam logic [7:0] DBU_SDATA_RESET = 8'h00;
  localparam int DBU_MODE_HI_POS = 7;
  localparam int DBU_MODE_LO_POS = 6;
  localparam int DBU_MULTIPROC_POS = 5;
  localparam int DBU_RX_EN_POS = 4;
  localparam int DBU_TX_NINTH_POS = 3;
  localparam int DBU_RX_NINTH_POS = 2;
  localparam int DBU_TX_DONE_POS = 1;
  localparam int DBU_RX_DONE_POS = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int DBU_MODE0_BIT_CLKS = 6;
  localparam int DBU_TICKS_PER_BIT = 16;
  localparam int DBU_M2_DIV_SLOW = 64;
  localparam int DBU_M2_DIV_FAST = 32;
  localparam int DBU_M2_PRE_SLOW = DBU_M2_DIV_SLOW / DBU_TICKS_PER_BIT;
  localparam int DBU_M2_PRE_FAST = DBU_M2_DIV_FAST / DBU_TICKS_PER_BIT;
  localparam int DBU_RX_MID_TICK = DBU_TICKS_PER_BIT / 2 - 1;
  localparam int DBU_LAST_DATA_IDX = 8;
  localparam int DBU_FINAL_IDX = 9;

  // ****************************************************************
  // Types
  // ****************************************************************
  localparam int DBU_STREAM_W = 9;
  localparam int DBU_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    DBU_MODE_SHIFT = 2'b00,
    DBU_MODE_8VAR = 2'b01,
    DBU_MODE_9FIX = 2'b10,
    DBU_MODE_9VAR = 2'b11
  } dbu_mode_t;

  typedef enum logic [1:0] {
    DBU_RX_IDLE = 2'b00,
    DBU_RX_FRAME = 2'b01,
    DBU_RX_SHIFT = 2'b10
  } dbu_rx_state_t;

endpackage

// >>> shared/dbu_stream_if.sv
// Purpose: Valid/ready word stream between the port and its buffer.
// Assumes: Word taken on a clock edge where valid and ready are high.
// Notes: Carries the ninth bit above the data byte.
`timescale 1ns/100ps
interface dbu_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/dbu_buf2.sv
// Purpose: Small first-in first-out buffer with valid/ready sides.
// Assumes: Both sides on the same clock.
// Notes: Full refuses, so the source must watch ready.
`timescale 1ns/100ps
module dbu_buf2 import dbu_pkg::*; #(
  parameter int W = DBU_STREAM_W,
  parameter int DEPTH = DBU_BUF_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  dbu_stream_if.snk i_in,
  dbu_stream_if.src o_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } dbu_buf_state_t;

  dbu_buf_state_t state_reg;
  dbu_buf_state_t state_next;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign i_in.ready = (state_reg.count != CW'(DEPTH));
  assign o_out.valid = (state_reg.count != '0);
  assign o_out.data = state_reg.mem[state_reg.rd_ptr];
  assign push = i_in.valid && i_in.ready;
  assign pop = o_out.valid && o_out.ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = i_in.data;
      state_next.wr_ptr = ptr_inc(state_reg.wr_ptr);
    end
    if (pop) begin
      state_next.rd_ptr = ptr_inc(state_reg.rd_ptr);
    end
    state_next.count = CW'(state_reg.count + CW'(push) - CW'(pop));
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  full_refuse_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (state_reg.count == CW'(DEPTH)) && !pop |=> !i_in.ready)
    else $error("Buffer accepted a word while full.");

  word_kept_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    push && !o_out.valid |=> o_out.valid && (o_out.data == $past(i_in.data)))
    else $error("Word pushed into empty buffer was not presented.");

endmodule

// >>> test/dbu_peer.sv
// Purpose: Serial peer that sends frames into the receive pin.
// Assumes: Bit period is given in core clocks.
// Notes: Line idles high between frames.
`timescale 1ns/100ps
module dbu_peer (
  input wire logic i_sys_clk,
  output logic o_line
);
  initial o_line = 1'b1;
  // Start bit, then nb bits LSB first; the caller puts the stop bit last.
  task automatic send(input logic [9:0] bits, input int nb, input int per);
    o_line <= 1'b0;
    repeat (per) @(posedge i_sys_clk);
    for (int i = 0; i < nb; i++) begin
      o_line <= bits[i];
      repeat (per) @(posedge i_sys_clk);
    end
    o_line <= 1'b1;
  endtask
endmodule

// >>> test/test_dbu_uart.sv
// Purpose: Self-checking bench of the debug serial port.
// Assumes: Timer1 overflows every 6 clocks, timer2 every 2 clocks.
// Notes: Mode 1 and 3 bit periods below follow from those overflow spacings.
`timescale 1ns/100ps
module test_dbu_uart;
  import dbu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wren = 1'b0, rden = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdata;
  logic dbl = 1'b0, txsel = 1'b0, rxsel = 1'b0, t1 = 1'b0, t2 = 1'b0;
  logic line, txd, oe, tflag, rflag, rxo, rdy;
  int cnt = 0, n_fail = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cnt <= (cnt == 5) ? 0 : cnt + 1;
    t1 <= (cnt == 5);
    t2 <= ~t2;
  end
  dbu_uart dbu_uart_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_wr(wren), .i_sfr_rd(rden), .i_sfr_wdata(wdat),
    .o_sfr_rdata(rdata), .i_rate_double(dbl), .i_tx_timer_select(txsel),
    .i_rx_timer_select(rxsel), .i_timer1_overflow_pulse(t1),
    .i_timer2_overflow_pulse(t2), .i_rxd(line), .o_rxd(rxo),
    .o_rxd_oe(oe), .o_txd(txd), .o_tx_done_flag(tflag),
    .o_rx_done_flag(rflag), .o_txbuf_ready(rdy));
  dbu_peer dbu_peer_i (.i_sys_clk(clk), .o_line(line));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [8:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wren <= 1'b1;
    @(posedge clk);
    wren <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rden <= 1'b1;
    @(posedge clk);
    rden <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Sends one word and samples the start and data bits at their middle.
  task automatic txrun(input logic [7:0] c, input logic d2, sl,
      input logic [8:0] v, input int nb, per);
    int k;
    @(posedge clk);
    dbl <= d2;
    txsel <= sl;
    wr(DBU_SCON_ADDR, c);
    wr(DBU_SDATA_ADDR, v[7:0]);
    k = 0;
    while (txd !== 1'b0 && k < 4000) begin
      cyc(1);
      k++;
    end
    if (k == 4000) begin
      n_fail++;
      give_verdict;
    end
    cyc(per / 2);
    chk("start", txd, 0);
    for (int i = 0; i < nb; i++) begin
      cyc(per);
      chk("bit", txd, v[i]);
    end
    chk("early flag", tflag, 0);
    cyc(per / 2 + 3);
    chk("tx flag", tflag, 1);
    chk("stop", txd, 1);
    cyc(per);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    logic [7:0] d;
    chk("idle", txd, 1);
    rd(DBU_SCON_ADDR, d);
    chk("ctrl", d, 0);
    chk("buf ready", rdy, 1);
    wr(DBU_SDATA_ADDR, 8'h3C);
    rd(DBU_SDATA_ADDR, d);
    chk("rx buffer", d, 0);
    chk("m0 data", rxo, 0);
    cyc(20);
    chk("m0 drive", oe, 1);
    chk("m0 early", tflag, 0);
    // This clear lands in the very cycle in which the flag is set.
    cyc(24);
    wr(DBU_SCON_ADDR, 8'h00);
    cyc(2);
    chk("m0 flag", tflag, 1);
    rd(DBU_SCON_ADDR, d);
    chk("ctrl flag", d, 8'h02);
    rd(8'h42, d);
    chk("unmapped", d, 0);
    $display("test_reset done");
  endtask
  task automatic test_tx;
    txrun(8'h88, 1'b1, 1'b0, 9'h1A5, 9, 32);
    txrun(8'h80, 1'b0, 1'b0, 9'h03C, 9, 64);
    txrun(8'h40, 1'b1, 1'b0, 9'h05A, 8, 96);
    txrun(8'h40, 1'b0, 1'b0, 9'h0C3, 8, 192);
    txrun(8'hC8, 1'b0, 1'b1, 9'h1E1, 9, 32);
    $display("test_tx done");
  endtask
  task automatic test_rx;
    logic [7:0] d;
    @(posedge clk);
    rxsel <= 1'b1;
    wr(DBU_SCON_ADDR, 8'h40);
    dbu_peer_i.send(10'h196, 9, 32);
    cyc(4);
    chk("rx off", rflag, 0);
    wr(DBU_SCON_ADDR, 8'h50);
    dbu_peer_i.send(10'h196, 9, 32);
    cyc(4);
    chk("rx flag", rflag, 1);
    rd(DBU_SDATA_ADDR, d);
    chk("rx data", d, 8'h96);
    rd(DBU_SCON_ADDR, d);
    chk("rx ctrl", d, 8'h55);
    $display("test_rx done");
  endtask
  task automatic test_filter;
    logic [7:0] d;
    wr(DBU_SCON_ADDR, 8'hF0);
    dbu_peer_i.send(10'h211, 10, 32);
    cyc(4);
    chk("filtered", rflag, 0);
    rd(DBU_SDATA_ADDR, d);
    chk("kept data", d, 8'h96);
    dbu_peer_i.send(10'h322, 10, 32);
    cyc(4);
    chk("passed", rflag, 1);
    rd(DBU_SDATA_ADDR, d);
    chk("m3 data", d, 8'h22);
    rd(DBU_SCON_ADDR, d);
    chk("m3 ctrl", d, 8'hF5);
    wr(DBU_SCON_ADDR, 8'h10);
    cyc(60);
    chk("m0 rx flag", rflag, 1);
    rd(DBU_SDATA_ADDR, d);
    chk("m0 rx data", d, 8'hFF);
    $display("test_filter done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    test_reset;
    test_tx;
    test_rx;
    test_filter;
    give_verdict;
  end
endmodule
